// >>> inc/tpc_regs.vh
`ifndef TPC_REGS_VH
`define TPC_REGS_VH
// Register offsets
`define TPC_REG_CTRL 4'h0
`define TPC_REG_STATUS 4'h1
`define TPC_REG_IRQ_STAT 4'h2
`define TPC_REG_IRQ_MASK 4'h3
`define TPC_REG_TOL 4'h4
`define TPC_REG_RANGE 4'h5
`define TPC_REG_LIST_IDX 4'h6
`define TPC_REG_LIST_CODE 4'h7
`define TPC_REG_LIST_XPOS 4'h8
`define TPC_REG_LIST_LEN 4'h9
// Status bit positions
`define TPC_ST_NO_CODE 0
`define TPC_ST_UNKNOWN 1
`define TPC_ST_SEQ 2
`define TPC_ST_SPACING 3
`define TPC_ST_DUP 4
`define TPC_ST_MISMATCH 5
`define TPC_ST_AWAIT 6
`define TPC_ST_ABS_OK 7
`define TPC_ST_REL_OK 8
// Reset values
`define TPC_TOL_RST 16'h000A
`define TPC_RANGE_RST 16'h0190
`define TPC_MASK_RST 7'h00
`define TPC_FLAGS_RST 7'h41
// Widths and sizes
`define TPC_CODE_W 32
`define TPC_POS_W 16
`define TPC_IDX_W 6
`define TPC_LIST_N 64
`endif

// >>> verilog/tpc_checker.v
// Implementation choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`include "tpc_regs.vh"
module tpc_checker (
	// Clock and reset
	input wire mclk,
	input wire rst,
	// Tag reader slots, update strobe
	input wire tag_upd,
	input wire slot0_valid,
	input wire [`TPC_CODE_W-1:0] slot0_code,
	input wire signed [`TPC_POS_W-1:0] slot0_rel,
	input wire slot1_valid,
	input wire [`TPC_CODE_W-1:0] slot1_code,
	input wire signed [`TPC_POS_W-1:0] slot1_rel,
	// Register port
	input wire [3:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [31:0] reg_rdata,
	// Position outputs
	output reg abs_valid,
	output reg [`TPC_POS_W-1:0] abs_pos,
	output reg rel_valid,
	output reg [`TPC_POS_W-1:0] rel_pos,
	// Status flags
	output reg no_code_flag,
	output reg unknown_tag_flag,
	output reg out_of_sequence_flag,
	output reg implausible_spacing_flag,
	output reg duplicate_code_flag,
	output reg position_mismatch_flag,
	output reg awaiting_initial_tag_status,
	// Interrupt
	output wire irq
);

	// ------------------------------------------------------------
	// Tag list storage (sorted by software, ascending x)
	// ------------------------------------------------------------
	reg [`TPC_CODE_W-1:0] list_code [0:`TPC_LIST_N-1];
	reg [`TPC_POS_W-1:0] list_xpos [0:`TPC_LIST_N-1];
	reg [`TPC_IDX_W-1:0] list_idx_q;
	reg [`TPC_IDX_W:0] list_len_q;
	// Software settings
	reg [`TPC_POS_W-1:0] tol_q;
	reg [`TPC_POS_W-1:0] range_q;
	reg [6:0] irq_stat_q;
	reg [6:0] irq_mask_q;
	reg check_en_q;

	// ------------------------------------------------------------
	// Lookup: hit vectors for both slot codes
	// ------------------------------------------------------------
	wire [`TPC_LIST_N-1:0] hit0;
	wire [`TPC_LIST_N-1:0] hit1;
	genvar gi;
	generate
		for (gi = 0; gi < `TPC_LIST_N; gi = gi + 1) begin : g_cmp
			assign hit0[gi] = (gi < list_len_q) && (list_code[gi] == slot0_code);
			assign hit1[gi] = (gi < list_len_q) && (list_code[gi] == slot1_code);
		end
	endgenerate

	// Priority encoder of a hit vector, lowest index
	// Lowest index wins if a code was loaded twice
	function [`TPC_IDX_W-1:0] enc;
		input [`TPC_LIST_N-1:0] v;
		integer k;
		begin
			enc = {`TPC_IDX_W{1'b0}};
			for (k = `TPC_LIST_N - 1; k >= 0; k = k - 1)
				if (v[k])
					enc = k[`TPC_IDX_W-1:0];
		end
	endfunction

	// Absolute difference of two positions
	function [`TPC_POS_W-1:0] absdiff;
		input [`TPC_POS_W-1:0] a;
		input [`TPC_POS_W-1:0] b;
		begin
			absdiff = (a > b) ? (a - b) : (b - a);
		end
	endfunction

	// Adjacency in sorted order, both directions
	function adjacent;
		input [`TPC_IDX_W-1:0] a;
		input [`TPC_IDX_W-1:0] b;
		begin
			// Seven-bit sums so the last entry never wraps onto the first
			adjacent = ({1'b0, a} + 7'h01 == {1'b0, b}) || ({1'b0, b} + 7'h01 == {1'b0, a});
		end
	endfunction

	// Write strobe aimed at one register offset
	function wr_hit;
		input wr;
		input [3:0] addr;
		input [3:0] off;
		begin
			wr_hit = wr && (addr == off);
		end
	endfunction

	// ------------------------------------------------------------
	// Combinational evaluation of the current slot pair
	// ------------------------------------------------------------
	// Slot codes found in the list, and where
	wire found0 = |hit0;
	wire found1 = |hit1;
	wire [`TPC_IDX_W-1:0] idx0 = enc(hit0);
	wire [`TPC_IDX_W-1:0] idx1 = enc(hit1);

	// Occupancy of the two slots
	wire both = slot0_valid && slot1_valid;
	wire any_valid = slot0_valid || slot1_valid;

	// Per-update error conditions
	wire dup_now = both && (slot0_code == slot1_code);
	wire unk_now = (slot0_valid && !found0) || (slot1_valid && !found1);
	// Pair checks only between two distinct listed tags
	wire known_both = both && found0 && found1 && !dup_now;

	// Listed x of each slot and the absolute positions built on them
	wire [`TPC_POS_W-1:0] x0 = list_xpos[idx0];
	wire [`TPC_POS_W-1:0] x1 = list_xpos[idx1];
	wire [`TPC_POS_W-1:0] a0 = x0 + slot0_rel;
	wire [`TPC_POS_W-1:0] a1 = x1 + slot1_rel;

	// Spread of the listed positions and of the computed ones
	wire [`TPC_POS_W-1:0] list_spread = absdiff(x0, x1);
	wire [`TPC_POS_W-1:0] pos_spread = absdiff(a0, a1);
	wire space_now = known_both && (list_spread > range_q);
	// Strictly above the tolerance; equal still counts as agreement
	wire mis_now = known_both && (pos_spread > tol_q);
	// Slot holds a code that the list knows
	wire known0 = slot0_valid && found0;
	wire known1 = slot1_valid && found1;
	// Newest known tag seen this update; slot1 wins when both are known
	wire new_ok = known0 || known1;
	wire [`TPC_IDX_W-1:0] new_idx = known1 ? idx1 : idx0;

	// ------------------------------------------------------------
	// Sequence tracking state
	// ------------------------------------------------------------
	// Last listed tag read; cleared only by reset
	reg have_last_q;
	reg [`TPC_IDX_W-1:0] last_idx_q;
	wire changed = new_ok && (!have_last_q || new_idx != last_idx_q);
	wire consec = changed && have_last_q && adjacent(last_idx_q, new_idx);
	wire jump = changed && have_last_q && !consec;

	// ------------------------------------------------------------
	// Update qualifier
	// ------------------------------------------------------------
	// Strobes arriving while checking is off are dropped whole
	// Flags and positions then hold their last values
	wire upd_take = tag_upd && check_en_q;

	// ------------------------------------------------------------
	// Next values of the sequence-driven status bits
	// ------------------------------------------------------------
	reg seq_d;
	reg await_d;
	reg restart;
	// Jump sets, step clears, otherwise hold
	always @* begin
		seq_d = out_of_sequence_flag;
		await_d = awaiting_initial_tag_status;
		restart = jump || (unk_now && !dup_now) || space_now || dup_now || mis_now;
		if (jump) begin
			seq_d = 1'b1;
		end else if (consec) begin
			seq_d = 1'b0;
		end
		// Any restarting flag outranks a good step
		if (restart) begin
			await_d = 1'b1;
		end else if (consec) begin
			await_d = 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Next values of the position outputs
	// ------------------------------------------------------------
	reg abs_valid_d;
	reg rel_valid_d;
	reg [`TPC_POS_W-1:0] abs_pos_d;
	reg [`TPC_POS_W-1:0] rel_pos_d;
	// Suppression per flag; any demanding flag wins
	always @* begin
		abs_valid_d = any_valid && !dup_now && !unk_now && !space_now && new_ok;
		rel_valid_d = any_valid && !dup_now;
		abs_pos_d = abs_pos;
		rel_pos_d = rel_pos;
		// Known slot0 first, then slot1, then an unlisted slot0
		if (known0) begin
			abs_pos_d = a0;
			rel_pos_d = slot0_rel;
		end else if (slot1_valid) begin
			abs_pos_d = a1;
			rel_pos_d = slot1_rel;
		end else if (slot0_valid) begin
			rel_pos_d = slot0_rel;
		end
	end

	// ------------------------------------------------------------
	// Flag and position update on each tag-read strobe taken while checking is on
	// ------------------------------------------------------------
	// Flag vector in status bit order
	wire [6:0] flags = {awaiting_initial_tag_status, position_mismatch_flag, duplicate_code_flag,
		implausible_spacing_flag, out_of_sequence_flag, unknown_tag_flag, no_code_flag};
	wire [6:0] flags_prev_rise;
	reg [6:0] flags_d1_q;
	// Rising edges of the flags since the last cycle
	assign flags_prev_rise = flags & ~flags_d1_q;

	always @(posedge mclk) begin
		if (rst) begin
			no_code_flag <= 1'b1;
			unknown_tag_flag <= 1'b0;
			out_of_sequence_flag <= 1'b0;
			implausible_spacing_flag <= 1'b0;
			duplicate_code_flag <= 1'b0;
			position_mismatch_flag <= 1'b0;
			awaiting_initial_tag_status <= 1'b1;
			have_last_q <= 1'b0;
			last_idx_q <= {`TPC_IDX_W{1'b0}};
			abs_valid <= 1'b0;
			rel_valid <= 1'b0;
			abs_pos <= {`TPC_POS_W{1'b0}};
			rel_pos <= {`TPC_POS_W{1'b0}};
		end else if (upd_take) begin
			// Flags judged together: a duplicate pair overrides no-code and unknown
			// No code, also raised when duplicates empty the slots
			no_code_flag <= !any_valid || dup_now;
			// Unknown tag hidden behind a duplicate pair
			unknown_tag_flag <= unk_now && !dup_now;
			// Pair flags fall as soon as one tag leaves
			implausible_spacing_flag <= space_now;
			duplicate_code_flag <= dup_now;
			position_mismatch_flag <= mis_now;
			if (dup_now) begin
				// Both slots dropped, sequence memory kept
				have_last_q <= have_last_q;
			end else if (new_ok) begin
				have_last_q <= 1'b1;
				last_idx_q <= new_idx;
			end
			// Sequence and restart state
			out_of_sequence_flag <= seq_d;
			awaiting_initial_tag_status <= await_d;
			// Position outputs with suppression
			abs_valid <= abs_valid_d;
			rel_valid <= rel_valid_d;
			abs_pos <= abs_pos_d;
			rel_pos <= rel_pos_d;
		end
	end

	// ------------------------------------------------------------
	// Interrupt status: rising flags set sticky bits
	// ------------------------------------------------------------
	always @(posedge mclk) begin
		if (rst) begin
			// Edge memory starts at the reset levels, so no false rise
			flags_d1_q <= `TPC_FLAGS_RST;
			irq_stat_q <= 7'h00;
		end else begin
			flags_d1_q <= flags;
			// Set wins over write-one-clear
			if (wr_hit(reg_wr, reg_addr, `TPC_REG_IRQ_STAT))
				irq_stat_q <= (irq_stat_q & ~reg_wdata[6:0]) | flags_prev_rise;
			else
				irq_stat_q <= irq_stat_q | flags_prev_rise;
		end
	end
	// Level output, follows mask writes at once
	assign irq = |(irq_stat_q & irq_mask_q);

	// ------------------------------------------------------------
	// Register writes
	// ------------------------------------------------------------
	always @(posedge mclk) begin
		if (rst) begin
			// Checking on, default tolerance and range
			check_en_q <= 1'b1;
			irq_mask_q <= `TPC_MASK_RST;
			tol_q <= `TPC_TOL_RST;
			range_q <= `TPC_RANGE_RST;
			list_idx_q <= {`TPC_IDX_W{1'b0}};
			list_len_q <= {(`TPC_IDX_W+1){1'b0}};
		end else if (reg_wr) begin
			// Unmapped offsets leave all settings alone
			case (reg_addr)
				`TPC_REG_CTRL: check_en_q <= reg_wdata[0];
				`TPC_REG_IRQ_MASK: irq_mask_q <= reg_wdata[6:0];
				`TPC_REG_TOL: tol_q <= reg_wdata[`TPC_POS_W-1:0];
				`TPC_REG_RANGE: range_q <= reg_wdata[`TPC_POS_W-1:0];
				`TPC_REG_LIST_IDX: list_idx_q <= reg_wdata[`TPC_IDX_W-1:0];
				`TPC_REG_LIST_LEN: list_len_q <= reg_wdata[`TPC_IDX_W:0];
				default: check_en_q <= check_en_q;
			endcase
		end
	end

	// ------------------------------------------------------------
	// List memory writes, no reset
	// ------------------------------------------------------------
	always @(posedge mclk) begin
		if (wr_hit(reg_wr, reg_addr, `TPC_REG_LIST_CODE))
			list_code[list_idx_q] <= reg_wdata;
		if (wr_hit(reg_wr, reg_addr, `TPC_REG_LIST_XPOS))
			list_xpos[list_idx_q] <= reg_wdata[`TPC_POS_W-1:0];
	end

	// ------------------------------------------------------------
	// Status word as seen by software
	// ------------------------------------------------------------
	// Flags in bits 0 to 6, position valids above them
	wire [31:0] status_word = {23'h000000, rel_valid, abs_valid, flags};

	// ------------------------------------------------------------
	// Register reads, data one cycle after the strobe
	// ------------------------------------------------------------
	always @(posedge mclk) begin
		if (rst) begin
			reg_rdata <= 32'h00000000;
		end else if (reg_rd) begin
			case (reg_addr)
				`TPC_REG_CTRL: reg_rdata <= {31'h00000000, check_en_q};
				`TPC_REG_STATUS: reg_rdata <= status_word;
				`TPC_REG_IRQ_STAT: reg_rdata <= {25'h0000000, irq_stat_q};
				`TPC_REG_IRQ_MASK: reg_rdata <= {25'h0000000, irq_mask_q};
				`TPC_REG_TOL: reg_rdata <= {16'h0000, tol_q};
				`TPC_REG_RANGE: reg_rdata <= {16'h0000, range_q};
				`TPC_REG_LIST_IDX: reg_rdata <= {26'h0000000, list_idx_q};
				`TPC_REG_LIST_CODE: reg_rdata <= list_code[list_idx_q];
				`TPC_REG_LIST_XPOS: reg_rdata <= {16'h0000, list_xpos[list_idx_q]};
				`TPC_REG_LIST_LEN: reg_rdata <= {25'h0000000, list_len_q};
				default: reg_rdata <= 32'h00000000;
			endcase
		end else begin
			// Data stand one cycle only, zero otherwise
			reg_rdata <= 32'h00000000;
		end
	end

endmodule

// >>> tb/tpc_checker_monitor.sv
`timescale 1ns/1ps
`include "tpc_regs.vh"
// ------------------
// Flag checker
// ------------------
module tpc_checker_monitor (
	// Clock and reset
	input wire mclk,
	input wire rst,
	// Tag slots
	input wire tag_upd,
	input wire slot0_valid,
	input wire [`TPC_CODE_W-1:0] slot0_code,
	input wire slot1_valid,
	input wire [`TPC_CODE_W-1:0] slot1_code,
	// Positions and flags
	input wire abs_valid,
	input wire rel_valid,
	input wire no_code_flag,
	input wire unknown_tag_flag,
	input wire out_of_sequence_flag,
	input wire implausible_spacing_flag,
	input wire duplicate_code_flag,
	input wire position_mismatch_flag,
	input wire awaiting_initial_tag_status
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	// Flags that restart the sequence
	wire any_err = unknown_tag_flag | out_of_sequence_flag | implausible_spacing_flag | duplicate_code_flag
		| position_mismatch_flag;
	// Update kinds
	sequence s_none; tag_upd && !slot0_valid && !slot1_valid; endsequence
	sequence s_one; tag_upd && (slot0_valid != slot1_valid); endsequence
	sequence s_dup; tag_upd && slot0_valid && slot1_valid && slot0_code == slot1_code; endsequence
	AST_NO_CODE_SET: assert property (s_none |=> no_code_flag)
		else $error("no code flag missing");
	AST_NO_CODE_CLR: assert property (s_one |=> !no_code_flag)
		else $error("no code flag stuck");
	AST_SUPPRESS_BOTH: assert property (no_code_flag || duplicate_code_flag |-> !abs_valid && !rel_valid)
		else $error("position not suppressed");
	AST_SUPPRESS_ABS: assert property (unknown_tag_flag || implausible_spacing_flag |-> !abs_valid)
		else $error("absolute not suppressed");
	AST_DUP_SET: assert property (s_dup |=> duplicate_code_flag && no_code_flag)
		else $error("duplicate not flagged");
	AST_PAIR_CLR: assert property (s_one |=> !implausible_spacing_flag && !position_mismatch_flag)
		else $error("pair flag stuck");
	AST_AWAIT_SET: assert property ($rose(any_err) |-> awaiting_initial_tag_status)
		else $error("awaiting status missing");
	AST_SEQ_ABS: assert property (out_of_sequence_flag && !no_code_flag && !unknown_tag_flag
		&& !implausible_spacing_flag && !duplicate_code_flag |-> abs_valid)
		else $error("absolute lost out of sequence");
endmodule
bind tpc_checker tpc_checker_monitor mon (.*);

// >>> tb/tpc_ctl_model.sv
`timescale 1ns/1ps
// ------------------
// Controller model
// ------------------
module tpc_ctl_model (
	// Clock
	input wire mclk,
	// Register port, master side
	output reg [3:0] reg_addr = 4'h0,
	output reg [31:0] reg_wdata = 32'h0,
	output reg reg_wr = 1'b0,
	output reg reg_rd = 1'b0
);
	// One access, then idle with inverted lines
	task access(input w, input [3:0] a, input [31:0] d);
		begin
			reg_addr <= a;
			reg_wdata <= d;
			reg_wr <= w;
			reg_rd <= !w;
			@(posedge mclk);
			reg_wr <= 1'b0;
			reg_rd <= 1'b0;
			reg_addr <= ~a;
			reg_wdata <= ~d;
			@(posedge mclk);
		end
	endtask
endmodule

// >>> tb/tpc_checker_tb_top.sv
`timescale 1ns/1ps
// ------------------
// Bench top
// ------------------
module tpc_checker_tb_top;
	reg mclk = 1'b0;
	reg rst = 1'b1;
	reg tag_upd = 1'b0;
	reg slot0_valid = 1'b0;
	reg slot1_valid = 1'b0;
	reg [31:0] slot0_code = 32'h0;
	reg [31:0] slot1_code = 32'h0;
	reg signed [15:0] slot0_rel = 16'h0;
	reg signed [15:0] slot1_rel = 16'h0;
	wire [3:0] reg_addr;
	wire [31:0] reg_wdata;
	wire reg_wr;
	wire reg_rd;
	wire [31:0] reg_rdata;
	wire abs_valid;
	wire rel_valid;
	wire irq;
	wire [15:0] abs_pos;
	wire [15:0] rel_pos;
	wire no_code_flag;
	wire unknown_tag_flag;
	wire out_of_sequence_flag;
	wire implausible_spacing_flag;
	wire duplicate_code_flag;
	wire position_mismatch_flag;
	wire awaiting_initial_tag_status;
	integer err_total = 0;
	integer comparisons = 0;
	integer i;
	reg [40:0] eq[$];
	reg [31:0] rq[$];
	reg us = 1'b0;
	reg rs = 1'b0;
	reg [7:0] rnd = 8'h29;
	wire [6:0] fl = {awaiting_initial_tag_status, position_mismatch_flag, duplicate_code_flag,
		implausible_spacing_flag, out_of_sequence_flag, unknown_tag_flag, no_code_flag};
	always #25 mclk = ~mclk;
	tpc_checker DUT (.*);
	tpc_ctl_model ctl (.*);
	// Compare and count
	// Pseudo-random source for stimulus
	function [7:0] lfsr(input [7:0] s);
		lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	task chk(input [47:0] seen, input [47:0] exp, input string what);
		begin
			comparisons = comparisons + 1;
			if (seen !== exp) begin
				err_total = err_total + 1;
				$display("wrong value %s expected %h seen %h", what, exp, seen);
			end
		end
	endtask
	task report_and_stop;
		begin
			$display("comparisons %0d mismatches %0d", comparisons, err_total);
			if (err_total == 0 && comparisons > 0)
				$display("Finished cleanly");
			else
				$display("Finished with errors");
			$finish;
		end
	endtask
	task rd(input [3:0] a, input [31:0] e);
		begin
			rq.push_back(e);
			ctl.access(1'b0, a, 32'h0);
		end
	endtask
	task wr(input [3:0] a, input [31:0] d);
		ctl.access(1'b1, a, d);
	endtask
	// Tag update with expected {flags, abs, rel, position}
	task u(input a0, input [31:0] k0, input [15:0] p0, input a1, input [31:0] k1, input [15:0] p1,
		input [8:0] f, input [15:0] ap);
		begin
			slot0_valid <= a0;
			slot0_code <= k0;
			slot0_rel <= p0;
			slot1_valid <= a1;
			slot1_code <= k1;
			slot1_rel <= p1;
			tag_upd <= 1'b1;
			eq.push_back({f, ap, f[0] ? p0 : 16'h0});
			@(posedge mclk);
			tag_upd <= 1'b0;
			@(posedge mclk);
		end
	endtask
	// Bounded wait for the interrupt level
	task wirq(input e);
		begin
			for (i = 0; i < 8 && irq !== e; i = i + 1)
				@(posedge mclk);
			if (irq !== e) begin
				err_total = err_total + 1;
				$display("wrong value irq expected %b seen %b", e, irq);
				report_and_stop;
			end
		end
	endtask
	// Result watcher
	always @(posedge mclk) begin
		if (us)
			chk({fl, abs_valid, rel_valid, abs_valid ? abs_pos : 16'h0, rel_valid ? rel_pos : 16'h0}, eq.pop_front(), "flags");
		if (rs)
			chk(reg_rdata, rq.pop_front(), "rdata");
		us <= tag_upd;
		rs <= reg_rd;
	end
	// Main sequence
	initial begin
		repeat (5) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		rd(4'h1, 32'h41);
		rd(4'h4, 32'h0A);
		rd(4'hF, 32'h0);
		for (i = 0; i < 4; i = i + 1) begin
			wr(4'h6, i);
			wr(4'h7, 32'h11 * (i + 1));
			wr(4'h8, 32'h3E8 + 32'h12C * i);
		end
		wr(4'h9, 32'h4);
		rnd = lfsr(rnd);
		u(1, 32'h11, {9'h0, rnd[6:0]}, 0, 32'h0, 16'h0, 9'h103, 16'h3E8 + rnd[6:0]);
		u(1, 32'h22, 16'h0, 0, 32'h0, 16'h0, 9'h003, 16'h514);
		u(1, 32'h22, 16'h96, 1, 32'h33, 16'hFF74, 9'h003, 16'h5AA);
		u(1, 32'h22, 16'h96, 1, 32'h33, 16'hFF75, 9'h183, 16'h5AA);
		u(1, 32'h44, 16'h0, 0, 32'h0, 16'h0, 9'h003, 16'h76C);
		$display("done sequence part");
		u(1, 32'h11, 16'h0, 0, 32'h0, 16'h0, 9'h113, 16'h3E8);
		u(1, 32'h22, 16'h0, 0, 32'h0, 16'h0, 9'h003, 16'h514);
		u(1, 32'h11, 16'h0, 0, 32'h0, 16'h0, 9'h003, 16'h3E8);
		wr(4'h5, 32'hFA);
		u(1, 32'h11, 16'h96, 1, 32'h22, 16'hFF6A, 9'h121, 16'h0);
		u(1, 32'h11, 16'h0, 0, 32'h0, 16'h0, 9'h003, 16'h3E8);
		u(1, 32'h99, 16'h0, 0, 32'h0, 16'h0, 9'h109, 16'h0);
		u(1, 32'h22, 16'h0, 0, 32'h0, 16'h0, 9'h003, 16'h514);
		wr(4'h0, 32'h0);
		rd(4'h0, 32'h0);
		u(1, 32'h99, 16'h0, 0, 32'h0, 16'h0, 9'h003, 16'h514);
		wr(4'h0, 32'h1);
		$display("done flag part");
		u(1, 32'h33, 16'h0, 1, 32'h33, 16'h0, 9'h144, 16'h0);
		rd(4'h1, 32'h51);
		repeat (8) @(posedge mclk);
		chk(irq, 1'b0, "masked irq");
		rd(4'h2, 32'h7F);
		wr(4'h3, 32'h10);
		wirq(1'b1);
		chk(irq, 1'b1, "irq");
		wr(4'h2, 32'h7F);
		wirq(1'b0);
		chk(irq, 1'b0, "cleared irq");
		rd(4'h2, 32'h0);
		u(0, 32'h0, 16'h0, 0, 32'h0, 16'h0, 9'h104, 16'h0);
		repeat (3) @(posedge mclk);
		chk(eq.size() + rq.size(), 0, "pending");
		$display("done interrupt part");
		report_and_stop;
	end
endmodule
